/* File: logic/ioc_io_cache.sv */
// Contract
// R1: read hit returns cache data, tag unchanged
// R2: invalid-line read returns memory data
// R3: read miss fills line, tag valid
// R4: write hit stays in cache only
// R5: write hit sets dirty, keeps address
// R6: line is sixteen bytes, four words
// R7: any longword address maps its own line
// R8: enable register holds four separate enables
// R9: reads return correctly positioned byte lanes
// R10: sized writes touch only addressed lanes; code writes map entries whole, ignoring reg_be
// R11: data ram stores any pattern anywhere
// R12: loopback write then read returns data
// R13: dma address translated through mapper entry
// R14: write miss allocates, memory untouched
// R15: dirty other line written back first
// R16: dma write invalidates central cache entry; code invalidates only on cached write hits, not on bypass writes
// R17: cache disabled bypasses to memory
// R18: software ram access triggers no traffic
`timescale 1ns/1ps
`default_nettype none
`include "ioc_regs.svh"
module ioc_io_cache #(
	parameter int LINES = 64,
	parameter int MAP_ENTRIES = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [3:0] reg_be,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// dma requester
	input wire logic dma_req,
	input wire logic dma_we,
	input wire logic [31:0] dma_addr,
	input wire logic [31:0] dma_wdata,
	input wire logic [3:0] dma_be,
	output logic dma_ack,
	output logic [31:0] dma_rdata,
	// system memory
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [3:0] mem_be,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// central cache invalidate
	output logic cc_inval,
	output logic [31:0] cc_inval_addr
);
	import ioc_pkg::*;

	localparam int IDX_W = $clog2(LINES);
	localparam int MAP_W = $clog2(MAP_ENTRIES);

	if (LINES < 2 || LINES > 64 || LINES != (1 << IDX_W) || MAP_ENTRIES < 2
		|| MAP_ENTRIES > 64 || MAP_ENTRIES != (1 << MAP_W)) begin : g_chk
		$error("ioc_io_cache: LINES and MAP_ENTRIES must be powers of two, 2..64");
	end

	function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic [3:0] enable_q;
	logic [31:0] tag_mem [LINES];
	logic [31:0] data_mem [LINES*4];
	logic [19:0] map_mem [MAP_ENTRIES];
	ioc_state_type state_q;
	logic [31:0] req_addr_q;
	logic [31:0] req_wdata_q;
	logic [3:0] req_be_q;
	logic req_we_q;
	logic [1:0] cnt_q;
	logic [31:0] dma_rdata_q;
	logic [31:0] reg_rdata_q;
	logic [31:0] rd_mux;
	logic cc_inval_q;
	logic [31:0] cc_inval_addr_q;

	wire logic cc_enable = enable_q[`IOC_EN_CC];
	wire logic io_cache_enable = enable_q[`IOC_EN_IOC];
	wire logic direct_mem_access_enable = enable_q[`IOC_EN_DMA];
	wire logic bus_loopback_enable = enable_q[`IOC_EN_LOOP];

	wire logic [IDX_W-1:0] line_idx = req_addr_q[IDX_W+3:`IOC_LINE_LSB];
	wire logic [IDX_W+1:0] word_idx = {line_idx, req_addr_q[3:2]};
	wire logic [IDX_W+1:0] fill_idx = {line_idx, cnt_q};
	wire logic [31:0] tag_word = tag_mem[line_idx];
	wire logic tag_valid = tag_word[`IOC_TAG_VALID];
	wire logic tag_dirty = tag_word[`IOC_TAG_DIRTY];
	wire logic hit = tag_valid && (tag_word[31:IDX_W+4] == req_addr_q[31:IDX_W+4]);
	wire logic in_look = (state_q == IOC_LOOK) && io_cache_enable;
	wire logic write_hit = in_look && hit && req_we_q;

	// software ram writes only while no dma is in flight
	wire logic sw_ok = reg_wr && (state_q == IOC_IDLE);
	wire logic sel_data = (reg_addr[11] == `IOC_DATA_SEL);
	wire logic sel_tag = (reg_addr[11:10] == `IOC_TAG_SEL);
	wire logic sel_map = (reg_addr[11:8] == `IOC_MAP_SEL);
	wire logic [IDX_W+1:0] sw_word = reg_addr[IDX_W+3:2];
	wire logic [IDX_W-1:0] sw_line = reg_addr[IDX_W+1:2];
	wire logic [MAP_W-1:0] sw_map = reg_addr[MAP_W+1:2];
	wire logic sw_data_hit = sel_data && (reg_addr[10:2] < 9'(LINES*4));
	wire logic sw_tag_hit = sel_tag && (reg_addr[9:2] < 8'(LINES));
	wire logic sw_map_hit = sel_map && (7'(reg_addr[7:2]) < 7'(MAP_ENTRIES));

	// R13: page frame replaced by mapper entry
	wire logic [31:0] xlat_addr = direct_mem_access_enable ?
		{map_mem[dma_addr[MAP_W+11:`IOC_PAGE_LSB]], dma_addr[11:0]} : dma_addr;

	// R8: four independent enable bits
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			enable_q <= `IOC_ENABLE_RST;
		end else if (reg_wr && reg_addr == `IOC_REG_ENABLE && reg_be[0]) begin
			enable_q <= reg_wdata[3:0];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= IOC_IDLE;
			cnt_q <= 2'h0;
			req_addr_q <= 32'h0;
			req_wdata_q <= 32'h0;
			req_be_q <= 4'h0;
			req_we_q <= 1'b0;
		end else begin
			unique case (state_q)
				IOC_IDLE: begin
					// R12: requests reach the cache only through loopback
					if (dma_req && bus_loopback_enable) begin
						req_addr_q <= {xlat_addr[31:2], 2'h0};
						req_wdata_q <= dma_wdata;
						req_be_q <= dma_be;
						req_we_q <= dma_we;
						state_q <= IOC_LOOK;
					end
				end
				IOC_LOOK: begin
					cnt_q <= 2'h0;
					// R17: cache off goes straight to memory
					if (!io_cache_enable) begin
						state_q <= IOC_BYP;
					end else if (hit) begin
						state_q <= IOC_DONE;
					// R15: evict dirty line before reuse
					end else if (tag_valid && tag_dirty) begin
						state_q <= IOC_WB;
					end else begin
						state_q <= IOC_FILL;
					end
				end
				IOC_WB: begin
					if (mem_ack) begin
						cnt_q <= cnt_q + 2'h1;
						if (cnt_q == `IOC_LAST_WORD) begin
							state_q <= IOC_FILL;
						end
					end
				end
				IOC_FILL: begin
					// R6: four word reads per line
					if (mem_ack) begin
						cnt_q <= cnt_q + 2'h1;
						if (cnt_q == `IOC_LAST_WORD) begin
							state_q <= IOC_LOOK;
						end
					end
				end
				IOC_BYP: begin
					if (mem_ack) begin
						state_q <= IOC_DONE;
					end
				end
				IOC_DONE: begin
					state_q <= IOC_IDLE;
				end
				default: begin
					state_q <= IOC_IDLE;
				end
			endcase
		end
	end

	// ram arrays hold no reset
	always_ff @(posedge clk) begin
		// R3: fill every word then mark line valid and clean
		if (state_q == IOC_FILL && mem_ack) begin
			data_mem[fill_idx] <= mem_rdata;
			if (cnt_q == `IOC_LAST_WORD) begin
				tag_mem[line_idx] <= {req_addr_q[31:4], 2'h0, 1'b1, 1'b0};
			end
		end
		// R4 R5 R14: write lands in cache, line turns dirty
		if (write_hit) begin
			data_mem[word_idx] <= lane_merge(data_mem[word_idx], req_wdata_q, req_be_q);
			tag_mem[line_idx] <= {tag_word[31:1], 1'b1};
		end
		// R18 R10 R11: direct ram writes, byte lanes for data and tag, whole map entry
		if (sw_ok && sw_data_hit) begin
			data_mem[sw_word] <= lane_merge(data_mem[sw_word], reg_wdata, reg_be);
		end
		if (sw_ok && sw_tag_hit) begin
			tag_mem[sw_line] <= lane_merge(tag_mem[sw_line], reg_wdata, reg_be);
		end
		if (sw_ok && sw_map_hit) begin
			map_mem[sw_map] <= reg_wdata[31:12];
		end
	end

	// R1 R2: answer from cache ram, or memory when bypassing
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dma_rdata_q <= 32'h0;
		end else if (in_look && hit && !req_we_q) begin
			dma_rdata_q <= data_mem[word_idx];
		end else if (state_q == IOC_BYP && mem_ack && !req_we_q) begin
			dma_rdata_q <= mem_rdata;
		end
	end

	// R16: drop central cache copy on cached dma write, not on bypass
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cc_inval_q <= 1'b0;
			cc_inval_addr_q <= 32'h0;
		end else begin
			cc_inval_q <= write_hit && cc_enable;
			if (write_hit && cc_enable) begin
				cc_inval_addr_q <= {req_addr_q[31:4], 4'h0};
			end
		end
	end

	// R9: whole word read, every lane in its place
	always_comb begin
		rd_mux = 32'h0;
		if (reg_addr == `IOC_REG_ENABLE) begin
			rd_mux = {28'h0, enable_q};
		end else if (reg_addr == `IOC_REG_STATUS) begin
			rd_mux = {28'h0, state_q != IOC_IDLE, state_q};
		end else if (sw_data_hit) begin
			rd_mux = data_mem[sw_word];
		end else if (sw_tag_hit) begin
			rd_mux = tag_mem[sw_line];
		end else if (sw_map_hit) begin
			rd_mux = {map_mem[sw_map], 12'h0};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_q <= 32'h0;
		end else begin
			reg_rdata_q <= reg_rd ? rd_mux : 32'h0;
		end
	end

	// R7: line address from full longword address
	assign mem_req = (state_q == IOC_WB) || (state_q == IOC_FILL) || (state_q == IOC_BYP);
	assign mem_we = (state_q == IOC_WB) || ((state_q == IOC_BYP) && req_we_q);
	assign mem_addr = (state_q == IOC_WB) ? {tag_word[31:4], cnt_q, 2'h0} :
		(state_q == IOC_FILL) ? {req_addr_q[31:4], cnt_q, 2'h0} : req_addr_q;
	assign mem_be = (state_q == IOC_BYP) ? req_be_q : 4'hf;
	assign mem_wdata = (state_q == IOC_WB) ? data_mem[fill_idx] : req_wdata_q;
	assign dma_ack = (state_q == IOC_DONE);
	assign dma_rdata = dma_rdata_q;
	assign reg_rdata = reg_rdata_q;
	assign cc_inval = cc_inval_q;
	assign cc_inval_addr = cc_inval_addr_q;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_hit_no_memory: // R1
		assert property (in_look && hit |=> state_q == IOC_DONE && !mem_req ##1 !mem_req)
		else $error("read or write hit touched memory");
	a_miss_fetch: // R2
		assert property (in_look && !hit && !(tag_valid && tag_dirty)
			|=> state_q == IOC_FILL && mem_req && !mem_we)
		else $error("clean miss did not fetch from memory");
	a_fill_then_hit: // R3
		assert property (state_q == IOC_FILL && mem_ack && cnt_q == `IOC_LAST_WORD
			|=> state_q == IOC_LOOK && hit && !tag_dirty)
		else $error("line fill left tag wrong");
	a_write_no_through: // R4
		assert property (write_hit |=> !mem_we [*2])
		else $error("write hit wrote memory");
	a_write_dirty: // R5
		assert property (write_hit |=> hit && tag_dirty && dma_ack)
		else $error("write hit tag not valid dirty");
	a_line_words: // R6
		assert property ((state_q == IOC_WB || state_q == IOC_FILL)
			|-> mem_addr[1:0] == 2'h0 && mem_addr[3:2] == cnt_q && mem_be == 4'hf)
		else $error("line transfer word address wrong");
	a_writeback_old: // R15
		assert property (in_look && !hit && tag_valid && tag_dirty
			|=> state_q == IOC_WB && mem_we && mem_addr[31:4] == $past(tag_word[31:4]))
		else $error("dirty victim not written back first");
	a_bypass_direct: // R17
		assert property (state_q == IOC_LOOK && !io_cache_enable
			|=> state_q == IOC_BYP && mem_req && mem_addr == $past(req_addr_q))
		else $error("disabled cache did not bypass");
	a_cc_invalidate: // R16
		assert property (write_hit && cc_enable
			|=> cc_inval && cc_inval_addr[31:4] == $past(req_addr_q[31:4]))
		else $error("central cache not invalidated");
	a_map_offset: // R13
		assert property (state_q == IOC_IDLE && dma_req && bus_loopback_enable
			|=> state_q == IOC_LOOK && req_addr_q[11:2] == $past(dma_addr[11:2]))
		else $error("page offset lost in translation");
	a_loop_gate: // R12
		assert property (state_q == IOC_IDLE && !bus_loopback_enable |=> state_q == IOC_IDLE)
		else $error("dma taken with loopback off");
	a_read_slot: // R9
		assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside its slot");
endmodule
`default_nettype wire

/* File: pkg/ioc_regs.svh */
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH
`define IOC_REG_ENABLE 12'h000
`define IOC_REG_STATUS 12'h004
`define IOC_MAP_SEL 4'h1
`define IOC_TAG_SEL 2'h1
`define IOC_DATA_SEL 1'h1
`define IOC_EN_CC 0
`define IOC_EN_IOC 1
`define IOC_EN_DMA 2
`define IOC_EN_LOOP 3
`define IOC_ENABLE_RST 4'h0
`define IOC_TAG_VALID 1
`define IOC_TAG_DIRTY 0
`define IOC_LAST_WORD 2'h3
`define IOC_PAGE_LSB 12
`define IOC_LINE_LSB 4
`endif

/* File: pkg/ioc_pkg.sv */
`default_nettype none
package ioc_pkg;
	typedef enum logic [2:0] {
		IOC_IDLE = 3'h0,
		IOC_LOOK = 3'h1,
		IOC_WB = 3'h2,
		IOC_FILL = 3'h3,
		IOC_BYP = 3'h4,
		IOC_DONE = 3'h5
	} ioc_state_type;
endpackage
`default_nettype wire

/* File: verification/ioc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ioc_mem_model (
	// clock
	input wire logic clk,
	// memory port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0] mem_be,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [4096];
	logic slow_q = 1'b0;
	int wr_count = 0;
	// every other cycle only, to stretch fills
	assign mem_ack = mem_req & slow_q;
	// released bus shows the inverse
	assign mem_rdata = mem_ack ? mem[mem_addr[13:2]] : ~mem[mem_addr[13:2]];
	always @(posedge clk) begin
		slow_q <= ~slow_q;
		if (mem_ack && mem_we) begin
			for (int b = 0; b < 4; b++) begin
				if (mem_be[b])
					mem[mem_addr[13:2]][8*b+:8] <= mem_wdata[8*b+:8];
			end
			wr_count <= wr_count + 1;
		end
	end
endmodule
`default_nettype wire

/* File: verification/ioc_io_cache_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ioc_io_cache_bench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0;
	logic [3:0] reg_be = 4'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic dma_req = 1'b0;
	logic dma_we = 1'b0;
	logic [31:0] dma_addr = 32'h0;
	logic [31:0] dma_wdata = 32'h0;
	logic [3:0] dma_be = 4'hf;
	logic dma_ack;
	logic [31:0] dma_rdata;
	logic mem_req, mem_we, mem_ack, cc_inval;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, cc_inval_addr;
	logic [3:0] mem_be;
	logic cc_seen = 1'b0;
	logic [31:0] cc_addr = 32'h0;
	logic [31:0] v;
	logic [31:0] pat [3] = '{32'h5a972c5a, 32'h05a972c5, 32'h2c5a5a97};
	int err_count = 0;
	int comparisons = 0;
	int n;
	always #50 clk = ~clk;
	ioc_io_cache u_ioc_io_cache (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
		.dma_wdata(dma_wdata), .dma_be(dma_be), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.cc_inval(cc_inval), .cc_inval_addr(cc_inval_addr));
	ioc_mem_model u_ioc_mem_model (.clk(clk), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));
	always @(posedge clk) begin
		if (cc_inval === 1'b1) begin
			cc_seen <= 1'b1;
			cc_addr <= cc_inval_addr;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		reg_be <= be;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic dma(input logic we, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] d);
		int i;
		@(posedge clk);
		dma_req <= 1'b1;
		dma_we <= we;
		dma_addr <= a;
		dma_wdata <= wd;
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			#1;
			if (dma_ack === 1'b1)
				break;
		end
		if (i == 300) begin
			err_count++;
			wrap_up();
		end else begin
			d = dma_rdata;
			@(posedge clk);
			dma_req <= 1'b0;
			dma_addr <= ~a;
			dma_wdata <= ~wd;
		end
	endtask
	initial begin
		for (int i = 0; i < 4; i++)
			u_ioc_mem_model.mem[8+i] = 32'h100 + i;
		u_ioc_mem_model.mem[260] = 32'h77;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rd(12'h000, v); chk(v, 32'h0);
		wr(12'h000, 32'hf, 4'h1); rd(12'h000, v); chk(v, 32'hf);
		wr(12'hffc, 32'h1, 4'hf); rd(12'hffc, v); chk(v, 32'h0);
		// all enables off before setting up state
		wr(12'h000, 32'h0, 4'h1);
		for (int i = 0; i < 12; i++)
			wr(12'h800 + 12'(4 * i), pat[i % 3], 4'hf);
		for (int i = 0; i < 12; i++) begin
			rd(12'h800 + 12'(4 * i), v); chk(v, pat[i % 3]);
		end
		wr(12'h800, 32'h00ab0000, 4'h4); rd(12'h800, v); chk(v, 32'h5aab2c5a);
		wr(12'h800, 32'h00001234, 4'h3); rd(12'h800, v); chk(v, 32'h5aab1234);
		for (int i = 0; i < 8; i++)
			wr(12'h400 + 12'(4 * i), 32'h0, 4'hf);
		for (int i = 0; i < 4; i++)
			wr(12'h810 + 12'(4 * i), ~(32'h10 + 4 * i), 4'hf);
		wr(12'h404, 32'h12, 4'hf);
		chk(u_ioc_mem_model.wr_count, 0);
		wr(12'h000, 32'ha, 4'h1);
		dma(1'b0, 32'h10, 32'h0, v); chk(v, ~32'h10);
		rd(12'h404, v); chk(v, 32'h12);
		dma(1'b0, 32'h24, 32'h0, v); chk(v, 32'h101);
		rd(12'h408, v); chk(v, 32'h22);
		for (int i = 0; i < 4; i++) begin
			rd(12'h820 + 12'(4 * i), v); chk(v, 32'h100 + i);
		end
		wr(12'h000, 32'hb, 4'h1);
		n = u_ioc_mem_model.wr_count;
		dma(1'b1, 32'h14, 32'h11223344, v);
		chk(u_ioc_mem_model.wr_count, n);
		rd(12'h814, v); chk(v, 32'h11223344);
		rd(12'h404, v); chk(v, 32'h13);
		chk(cc_seen, 1); chk(cc_addr, 32'h10);
		dma(1'b1, 32'h30, 32'h55, v);
		rd(12'h40c, v); chk(v, 32'h33);
		chk(cc_addr, 32'h30);
		chk(u_ioc_mem_model.wr_count, n);
		dma(1'b0, 32'h410, 32'h0, v); chk(v, 32'h77);
		for (int i = 0; i < 4; i++)
			chk(u_ioc_mem_model.mem[4+i], (i == 1) ? 32'h11223344 : ~(32'h10 + 4 * i));
		rd(12'h404, v); chk(v, 32'h412);
		wr(12'h000, 32'h8, 4'h1);
		dma(1'b1, 32'h40, 32'h600d, v); dma(1'b0, 32'h40, 32'h0, v);
		chk(v, 32'h600d);
		chk(u_ioc_mem_model.mem[16], 32'h600d);
		rd(12'h410, v); chk(v, 32'h0);
		// mapper entry written before translation is enabled
		wr(12'h100, 32'h00003000, 4'hf); wr(12'h000, 32'hc, 4'h1);
		dma(1'b1, 32'h44, 32'h99, v); dma(1'b0, 32'h44, 32'h0, v);
		chk(v, 32'h99);
		chk(u_ioc_mem_model.mem[12'hc11], 32'h99);
		wrap_up();
	end
endmodule
`default_nettype wire
